/* File: src/carrier_oscillator_tuning_ctrl.sv */
// Tuning word, start phase and update control for the carrier oscillator.
`timescale 1ns/10ps

// Notes on behaviour
// - The 32-bit tuning word is built from four byte registers, low byte at the lowest address.
// - Writing the tuning word bytes only stages them; the active frequency stays unchanged.
// - A 0-to-1 write of update bit 0 loads the staged word once; holding it at 1 does nothing.
// - After the load the update acknowledge bit 1 reads as 1.
// - A 16-bit start phase, low byte first, becomes the carrier phase whenever it is reset.
// - The start phase is twos complement with 0.0055 degree steps over a full turn.
// - Setting bit 4 arms an oscillator reset on the next extended frame-sync pulse.
// - Bit 5 reads as 1 once a frame-sync pulse has actually reset the oscillator.
// - A 10-bit I-path skew is held as bits 7..0 low and bits 9..8 in bits 1..0 of the high register.
module carrier_oscillator_tuning_ctrl
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        frame_sync,
    output logic      [31:0] carrier_tuning_word,
    output logic      [15:0] carrier_start_phase,
    output logic      [9:0]  i_path_skew,
    output logic             osc_reset_pulse,
    output logic      [31:0] carrier_phase_acc
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]  staged_ff [4];
    logic [7:0]  nxt_staged [4];
    logic [31:0] active_word_ff,  nxt_active_word;
    logic [15:0] start_phase_ff,  nxt_start_phase;
    logic [9:0]  i_skew_ff,       nxt_i_skew;
    logic        tuning_update_req_ff, nxt_tuning_update_req;
    logic        tuning_update_ack_ff, nxt_tuning_update_ack;
    logic        frame_reset_req_ff,   nxt_frame_reset_req;
    logic        frame_reset_ack_ff,   nxt_frame_reset_ack;
    carrier_osc_pkg::frame_state_e frame_state_ff, nxt_frame_state;
    logic [31:0] acc_ff,          nxt_acc;
    logic        osc_reset_ff,    nxt_osc_reset;
    logic [7:0]  rdata_ff,        nxt_rdata;
    logic        frame_meta_ff, frame_sync_ff, frame_prev_ff;
    logic        frame_event;
    logic        ctrl_wr;

    // ------------------------------------------------------------------
    // Frame-sync input synchroniser and edge detect
    // ------------------------------------------------------------------
    // The pin is asynchronous, so only the second stage feeds the edge detect.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            frame_meta_ff <= 1'b0;
            frame_sync_ff <= 1'b0;
            frame_prev_ff <= 1'b0;
        end
        else
        begin
            frame_meta_ff <= frame_sync;
            frame_sync_ff <= frame_meta_ff;
            frame_prev_ff <= frame_sync_ff;
        end
    end

    assign frame_event = frame_sync_ff & ~frame_prev_ff;
    assign ctrl_wr     = reg_wr && (reg_addr == carrier_osc_pkg::UPDATE_CONTROL_ADDR);

    // ------------------------------------------------------------------
    // Register writes, update handshake and frame reset
    // ------------------------------------------------------------------
    // Next values of every register except the synchroniser and read data, and of the oscillator accumulator.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            nxt_staged[i] = staged_ff[i];
        end
        nxt_active_word       = active_word_ff;
        nxt_start_phase       = start_phase_ff;
        nxt_i_skew            = i_skew_ff;
        nxt_tuning_update_req = tuning_update_req_ff;
        nxt_tuning_update_ack = tuning_update_ack_ff;
        nxt_frame_reset_req   = frame_reset_req_ff;
        nxt_frame_reset_ack   = frame_reset_ack_ff;
        nxt_frame_state       = frame_state_ff;
        nxt_osc_reset         = 1'b0;

        if (reg_wr)
        begin
            case (reg_addr)
                carrier_osc_pkg::TUNING_WORD_BYTE0_ADDR:  nxt_staged[0] = reg_wdata;
                carrier_osc_pkg::TUNING_WORD_BYTE1_ADDR:  nxt_staged[1] = reg_wdata;
                carrier_osc_pkg::TUNING_WORD_BYTE2_ADDR:  nxt_staged[2] = reg_wdata;
                carrier_osc_pkg::TUNING_WORD_BYTE3_ADDR:  nxt_staged[3] = reg_wdata;
                carrier_osc_pkg::CARRIER_PHASE_LOW_ADDR:  nxt_start_phase[7:0] = reg_wdata;
                carrier_osc_pkg::CARRIER_PHASE_HIGH_ADDR: nxt_start_phase[15:8] = reg_wdata;
                carrier_osc_pkg::I_PATH_SKEW_LOW_ADDR:    nxt_i_skew[7:0] = reg_wdata;
                carrier_osc_pkg::I_PATH_SKEW_HIGH_ADDR:   nxt_i_skew[9:8] = reg_wdata[1:0];
                default:                                  nxt_i_skew = i_skew_ff;
            endcase
        end

        // The load uses the staged bytes as they stand before this write cycle.
        if (ctrl_wr)
        begin
            nxt_tuning_update_req = reg_wdata[carrier_osc_pkg::TUNING_UPDATE_REQ_BIT];
            nxt_frame_reset_req   = reg_wdata[carrier_osc_pkg::FRAME_RESET_REQ_BIT];
            if (!tuning_update_req_ff && reg_wdata[carrier_osc_pkg::TUNING_UPDATE_REQ_BIT])
            begin
                nxt_active_word       = {staged_ff[3], staged_ff[2], staged_ff[1], staged_ff[0]};
                nxt_tuning_update_ack = 1'b1;
            end
            else if (!reg_wdata[carrier_osc_pkg::TUNING_UPDATE_REQ_BIT])
            begin
                nxt_tuning_update_ack = 1'b0;
            end
            if (!frame_reset_req_ff && reg_wdata[carrier_osc_pkg::FRAME_RESET_REQ_BIT])
            begin
                nxt_frame_state = carrier_osc_pkg::FRAME_ARMED;
            end
            else if (!reg_wdata[carrier_osc_pkg::FRAME_RESET_REQ_BIT])
            begin
                nxt_frame_reset_ack = 1'b0;
                nxt_frame_state     = carrier_osc_pkg::FRAME_IDLE;
            end
        end

        // A frame pulse while armed resets the oscillator; its ack set beats a clear.
        case (frame_state_ff)
            carrier_osc_pkg::FRAME_IDLE:
            begin
                // Frame pulses are ignored while nothing is armed.
                nxt_osc_reset = 1'b0;
            end
            carrier_osc_pkg::FRAME_ARMED:
            begin
                if (frame_event)
                begin
                    nxt_osc_reset       = 1'b1;
                    nxt_frame_reset_ack = 1'b1;
                    nxt_frame_state     = carrier_osc_pkg::FRAME_IDLE;
                end
            end
            default:
            begin
                nxt_frame_state = carrier_osc_pkg::FRAME_IDLE;
            end
        endcase

        // Reset places the start phase at the top of the accumulator; its MSB is the sign.
        if (osc_reset_ff)
        begin
            nxt_acc = {start_phase_ff, 16'h0000};
        end
        else
        begin
            nxt_acc = 32'(acc_ff + active_word_ff); // Wraps modulo a full turn.
        end
    end

    // Registers for the state above.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                staged_ff[i] <= carrier_osc_pkg::BYTE_RESET;
            end
            active_word_ff       <= carrier_osc_pkg::TUNING_WORD_RESET;
            start_phase_ff       <= carrier_osc_pkg::START_PHASE_RESET;
            i_skew_ff            <= carrier_osc_pkg::I_SKEW_RESET;
            tuning_update_req_ff <= 1'b0;
            tuning_update_ack_ff <= 1'b0;
            frame_reset_req_ff   <= 1'b0;
            frame_reset_ack_ff   <= 1'b0;
            frame_state_ff       <= carrier_osc_pkg::FRAME_IDLE;
            acc_ff               <= 32'h0000_0000;
            osc_reset_ff         <= 1'b0;
        end
        else
        begin
            staged_ff            <= nxt_staged;
            active_word_ff       <= nxt_active_word;
            start_phase_ff       <= nxt_start_phase;
            i_skew_ff            <= nxt_i_skew;
            tuning_update_req_ff <= nxt_tuning_update_req;
            tuning_update_ack_ff <= nxt_tuning_update_ack;
            frame_reset_req_ff   <= nxt_frame_reset_req;
            frame_reset_ack_ff   <= nxt_frame_reset_ack;
            frame_state_ff       <= nxt_frame_state;
            acc_ff               <= nxt_acc;
            osc_reset_ff         <= nxt_osc_reset;
        end
    end

    // ------------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------------
    // Read data is registered one cycle after the strobe; unmapped offsets read zero.
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (reg_rd)
        begin
            case (reg_addr)
                carrier_osc_pkg::TUNING_WORD_BYTE0_ADDR:  nxt_rdata = staged_ff[0];
                carrier_osc_pkg::TUNING_WORD_BYTE1_ADDR:  nxt_rdata = staged_ff[1];
                carrier_osc_pkg::TUNING_WORD_BYTE2_ADDR:  nxt_rdata = staged_ff[2];
                carrier_osc_pkg::TUNING_WORD_BYTE3_ADDR:  nxt_rdata = staged_ff[3];
                carrier_osc_pkg::CARRIER_PHASE_LOW_ADDR:  nxt_rdata = start_phase_ff[7:0];
                carrier_osc_pkg::CARRIER_PHASE_HIGH_ADDR: nxt_rdata = start_phase_ff[15:8];
                carrier_osc_pkg::UPDATE_CONTROL_ADDR:
                    nxt_rdata = {2'b00, frame_reset_ack_ff, frame_reset_req_ff,
                                 2'b00, tuning_update_ack_ff, tuning_update_req_ff};
                carrier_osc_pkg::I_PATH_SKEW_LOW_ADDR:    nxt_rdata = i_skew_ff[7:0];
                carrier_osc_pkg::I_PATH_SKEW_HIGH_ADDR:   nxt_rdata = {6'h00, i_skew_ff[9:8]};
                default:                                  nxt_rdata = 8'h00;
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // All outputs come straight from flip-flops.
    assign reg_rdata           = rdata_ff;
    assign carrier_tuning_word = active_word_ff;
    assign carrier_start_phase = start_phase_ff;
    assign i_path_skew         = i_skew_ff;
    assign osc_reset_pulse     = osc_reset_ff;
    assign carrier_phase_acc   = acc_ff;

endmodule

/* File: src/carrier_osc_pkg.sv */
// Register map, field positions, reset values and states of the carrier oscillator control.
package carrier_osc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TUNING_WORD_BYTE0_ADDR  = 8'h30;
    localparam logic [7:0] TUNING_WORD_BYTE1_ADDR  = 8'h31;
    localparam logic [7:0] TUNING_WORD_BYTE2_ADDR  = 8'h32;
    localparam logic [7:0] TUNING_WORD_BYTE3_ADDR  = 8'h33;
    localparam logic [7:0] CARRIER_PHASE_LOW_ADDR  = 8'h34;
    localparam logic [7:0] CARRIER_PHASE_HIGH_ADDR = 8'h35;
    localparam logic [7:0] UPDATE_CONTROL_ADDR     = 8'h36;
    localparam logic [7:0] I_PATH_SKEW_LOW_ADDR    = 8'h38;
    localparam logic [7:0] I_PATH_SKEW_HIGH_ADDR   = 8'h39;

    // ------------------------------------------------------------------
    // Fields of the update control register
    // ------------------------------------------------------------------
    localparam int TUNING_UPDATE_REQ_BIT = 0;
    localparam int TUNING_UPDATE_ACK_BIT = 1;
    localparam int FRAME_RESET_REQ_BIT   = 4;
    localparam int FRAME_RESET_ACK_BIT   = 5;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int TUNING_WORD_W = 32;
    localparam int START_PHASE_W = 16;
    localparam int I_SKEW_W      = 10;
    localparam int ACC_W         = 32;

    localparam logic [31:0] TUNING_WORD_RESET = 32'h0000_0000;
    localparam logic [15:0] START_PHASE_RESET = 16'h0000;
    localparam logic [9:0]  I_SKEW_RESET      = 10'h000;
    localparam logic [7:0]  BYTE_RESET        = 8'h00;

    // Frame reset arming states.
    typedef enum logic [0:0] {
        FRAME_IDLE,
        FRAME_ARMED
    } frame_state_e;

endpackage

/* File: verification/carrier_osc_sva.sv */
// Concurrent checks on the ports of the carrier oscillator control.
`timescale 1ns/10ps
module carrier_osc_sva
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        frame_sync,
    input wire logic [31:0] carrier_tuning_word,
    input wire logic [15:0] carrier_start_phase,
    input wire logic [9:0]  i_path_skew,
    input wire logic        osc_reset_pulse,
    input wire logic [31:0] carrier_phase_acc
);
    logic [31:0] stg_ff;
    logic [31:0] nxt_stg;
    logic        req_ff;
    logic        nxt_req;
    logic        upd;

    // Mirror of the staged word and request bit, so loads can be judged from the ports.
    assign upd = reg_wr && reg_addr == 8'h36;
    always_comb
    begin
        nxt_stg = stg_ff;
        nxt_req = upd ? reg_wdata[0] : req_ff;
        if (reg_wr && reg_addr[7:2] == 6'h0c)
            nxt_stg[reg_addr[1:0] * 8 +: 8] = reg_wdata;
    end
    always_ff @(posedge ref_clk)
    begin
        stg_ff <= rst ? 32'h0000_0000 : nxt_stg;
        req_ff <= rst ? 1'b0 : nxt_req;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_WORD_LOAD: assert property (upd && reg_wdata[0] && !req_ff |=>
        carrier_tuning_word == stg_ff) else $error("tuning word not loaded on request edge");
    AST_WORD_HOLD: assert property (upd && req_ff |=> $stable(carrier_tuning_word))
        else $error("tuning word reloaded while request held");
    AST_WORD_STAGE: assert property (!upd |=> $stable(carrier_tuning_word))
        else $error("tuning word changed without update");
    AST_PHASE_LOW: assert property (reg_wr && reg_addr == 8'h34 |=>
        carrier_start_phase[7:0] == $past(reg_wdata)) else $error("start phase low byte wrong");
    AST_PHASE_HIGH: assert property (reg_wr && reg_addr == 8'h35 |=>
        carrier_start_phase[15:8] == $past(reg_wdata)) else $error("start phase high byte wrong");
    AST_SKEW_LOW: assert property (reg_wr && reg_addr == 8'h38 |=>
        i_path_skew[7:0] == $past(reg_wdata)) else $error("skew low bits wrong");
    AST_SKEW_HIGH: assert property (reg_wr && reg_addr == 8'h39 |=>
        i_path_skew == {$past(reg_wdata[1:0]), $past(i_path_skew[7:0])})
        else $error("skew high bits wrong");
    AST_PULSE_ONE: assert property (osc_reset_pulse |=> !osc_reset_pulse)
        else $error("oscillator reset pulse longer than one cycle");
    AST_PULSE_CAUSE: assert property (osc_reset_pulse |-> $past(frame_sync, 3))
        else $error("oscillator reset without frame sync");
    AST_ACC_LOAD: assert property (osc_reset_pulse |=>
        carrier_phase_acc == {$past(carrier_start_phase), 16'h0000})
        else $error("accumulator not loaded with start phase");
    AST_ACC_RUN: assert property (!osc_reset_pulse |=> carrier_phase_acc ==
        $past(carrier_phase_acc) + $past(carrier_tuning_word)) else $error("accumulator step wrong");
endmodule

bind carrier_oscillator_tuning_ctrl carrier_osc_sva carrier_osc_sva_i (.ref_clk(ref_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_sync(frame_sync), .carrier_tuning_word(carrier_tuning_word),
    .carrier_start_phase(carrier_start_phase), .i_path_skew(i_path_skew),
    .osc_reset_pulse(osc_reset_pulse), .carrier_phase_acc(carrier_phase_acc));

/* File: verification/testbench.sv */
// Self-checking bench for the carrier oscillator control.
`timescale 1ns/10ps
module testbench;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    logic        frame_sync = 1'b0;
    logic [7:0]  reg_rdata;
    logic [31:0] carrier_tuning_word;
    logic [15:0] carrier_start_phase;
    logic [9:0]  i_path_skew;
    logic        osc_reset_pulse;
    logic [31:0] carrier_phase_acc;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          n_pulse = 0;
    int          cycles = 0;
    int          i;

    always #10 ref_clk = ~ref_clk;

    carrier_oscillator_tuning_ctrl carrier_oscillator_tuning_ctrl_i (.ref_clk(ref_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_sync(frame_sync), .carrier_tuning_word(carrier_tuning_word),
        .carrier_start_phase(carrier_start_phase), .i_path_skew(i_path_skew),
        .osc_reset_pulse(osc_reset_pulse), .carrier_phase_acc(carrier_phase_acc));

    task automatic final_report();
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask

    // Strobes last one cycle; outputs are looked at just after the edge that took them.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        cmp("reg_rdata", {24'h00_0000, exp}, {24'h00_0000, reg_rdata});
    endtask

    // Held high well past the two-stage synchroniser so the event cannot be missed.
    task automatic frame();
        @(posedge ref_clk);
        frame_sync <= 1'b1;
        repeat (6) @(posedge ref_clk);
        frame_sync <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask

    // Counts reset pulses and cuts a hang short.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (osc_reset_pulse === 1'b1)
            n_pulse++;
        if (cycles == 2000)
        begin
            n_fail++;
            final_report();
        end
    end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        for (i = 8'h30; i <= 8'h39; i++)
            rd(8'(i), 8'h00);
        for (i = 0; i < 4; i++)
            wr(8'(8'h30 + i), 8'(8'h11 * (i + 1)));
        cmp("word", 32'h0000_0000, carrier_tuning_word);
        rd(8'h33, 8'h44);
        wr(8'h36, 8'h01);
        cmp("word", 32'h4433_2211, carrier_tuning_word);
        rd(8'h36, 8'h03);
        wr(8'h30, 8'h99);
        wr(8'h36, 8'hcd);
        cmp("word", 32'h4433_2211, carrier_tuning_word);
        rd(8'h36, 8'h03);
        wr(8'h36, 8'h00);
        rd(8'h36, 8'h00);
        wr(8'h36, 8'h01);
        cmp("word", 32'h4433_2299, carrier_tuning_word);
        wr(8'h38, 8'h5a);
        wr(8'h39, 8'hff);
        cmp("skew", 32'h0000_035a, {22'h00_0000, i_path_skew});
        rd(8'h39, 8'h03);
        wr(8'h35, 8'h80);
        cmp("reg_rdata", 32'h0000_0003, {24'h00_0000, reg_rdata});
        wr(8'h34, 8'h01);
        cmp("phase", 32'h0000_8001, {16'h0000, carrier_start_phase});
        frame();
        cmp("pulses", 32'h0000_0000, n_pulse);
        wr(8'h36, 8'h11);
        frame();
        cmp("pulses", 32'h0000_0001, n_pulse);
        rd(8'h36, 8'h33);
        frame();
        cmp("pulses", 32'h0000_0001, n_pulse);
        wr(8'h36, 8'h01);
        rd(8'h36, 8'h03);
        wr(8'h36, 8'h11);
        frame();
        cmp("pulses", 32'h0000_0002, n_pulse);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        cmp("word", 32'h0000_0000, carrier_tuning_word);
        final_report();
    end
endmodule
